// File: alu_branch_pkg.sv
// shared constants for the alu/branch instruction decoder
// assumes a 16-bit instruction word and 8-bit data path
package alu_branch_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 21;
    localparam int BANK_W = 4;
    // upper-byte opcode patterns (masked compare)
    localparam logic [7:0] OPC_ADDC = 8'h20; // 0010 00da
    localparam logic [7:0] MSK_ADDC = 8'hFC;
    localparam logic [7:0] OPC_ANDL = 8'h0B; // 0000 1011
    localparam logic [7:0] MSK_FULL = 8'hFF;
    localparam logic [7:0] OPC_ANDR = 8'h14; // 0001 01da
    localparam logic [7:0] OPC_BCLR = 8'h90; // 1001 bbba
    localparam logic [7:0] MSK_BCLR = 8'hF0;
    localparam logic [7:0] OPC_BRC = 8'hE2;
    localparam logic [7:0] OPC_BRNC = 8'hE3;
    localparam logic [7:0] OPC_BRN = 8'hE6;
    localparam logic [7:0] OPC_BRNN = 8'hE7;
    localparam logic [7:0] OPC_BRNOV = 8'hE5;
    // operand bit positions in the upper byte
    localparam int D_BIT = 1;
    localparam int A_BIT = 0;
    localparam int B_LSB = 1;
    // access bank: low half of bank 0, high half of the top bank
    localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 21'h000000;
    typedef enum logic [1:0] {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_PROCESS = 2'b10,
        PH_WRITE = 2'b11
    } phase_t;
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } flags_t;
endpackage

// File: alu_exec_if.sv
// carrier between the sequencer and the arithmetic unit
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
`default_nettype none
interface alu_exec_if;
    import alu_branch_pkg::*;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] opnd;
    logic carry_in;
    logic sel_add;
    logic sel_and;
    logic sel_bclr;
    logic [2:0] bit_sel;
    logic [DATA_W-1:0] result;
    flags_t flags_out;
    logic [4:0] flag_we;
    modport seq (output acc, opnd, carry_in, sel_add, sel_and, sel_bclr, bit_sel,
                 input result, flags_out, flag_we);
    modport alu (input acc, opnd, carry_in, sel_add, sel_and, sel_bclr, bit_sel,
                 output result, flags_out, flag_we);
endinterface
`default_nettype wire

// File: alu_exec_unit.sv
// combinational arithmetic for add-with-carry, and, and bit clear
// assumes the sequencer holds the operands stable through processing
`timescale 1ns/1ps
`default_nettype none
module alu_exec_unit
    import alu_branch_pkg::*;
(
    alu_exec_if.alu x
);
    logic [DATA_W:0] sum;
    logic [4:0] lo_sum;
    logic [DATA_W-1:0] and_res;
    logic [DATA_W-1:0] clr_mask;

    // add path, nibble sum gives digit carry
    always_comb begin
        sum = {1'b0, x.acc} + {1'b0, x.opnd} + {{DATA_W{1'b0}}, x.carry_in};
        lo_sum = {1'b0, x.acc[3:0]} + {1'b0, x.opnd[3:0]} + {4'h0, x.carry_in};
        and_res = x.acc & x.opnd;
        clr_mask = ~(8'h01 << x.bit_sel);
    end

    // result and flag select; write enables order n,ov,z,dc,c
    always_comb begin
        x.result = x.opnd;
        x.flags_out = '0;
        x.flag_we = 5'h00;
        if (x.sel_add) begin
            x.result = sum[DATA_W-1:0];
            x.flags_out.c = sum[DATA_W];
            x.flags_out.dc = lo_sum[4];
            x.flags_out.z = (sum[DATA_W-1:0] == DATA_RST);
            x.flags_out.n = sum[DATA_W-1];
            x.flags_out.ov = (x.acc[DATA_W-1] == x.opnd[DATA_W-1])
                && (sum[DATA_W-1] != x.acc[DATA_W-1]);
            x.flag_we = 5'h1F;
        end else if (x.sel_and) begin
            x.result = and_res;
            x.flags_out.z = (and_res == DATA_RST);
            x.flags_out.n = and_res[DATA_W-1];
            x.flag_we = 5'h14; // only n and z
        end else if (x.sel_bclr) begin
            x.result = x.opnd & clr_mask; // no flag enables
        end
    end
endmodule
`default_nettype wire

// File: alu_branch_instr_decode.sv
// four-phase decode/execute core for the add-with-carry, and, bit
// clear and conditional branch instructions.
// assumes the fetch side holds INSTR and INSTR_ADDR for a whole cycle
// and the register file answers RF_RDATA combinationally.
//
// Overview of operation
// - add-with-carry sums accumulator, register, carry
// - d picks accumulator or register destination
// - a=0 access bank, a=1 bank pointer
// - and-literal: accumulator and literal, n z
// - and-register: result per d, n z
// - bit clear by read-modify-write, no flags
// - branch offset signed, doubled before adding
// - taken branch: pc+2+2n, two cycles
// - branch on carry set
// - branch on carry clear
// - branch on negative set
// - branch on negative clear
// - branch on overflow clear
`timescale 1ns/1ps
`default_nettype none
module alu_branch_instr_decode
    import alu_branch_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [15:0] INSTR,
    input wire logic [PC_W-1:0] INSTR_ADDR,
    input wire logic [BANK_W-1:0] BANK_SELECT_POINTER,
    input wire logic [DATA_W-1:0] RF_RDATA,
    output logic [BANK_W+DATA_W-1:0] RF_ADDR,
    output logic RF_RE,
    output logic [DATA_W-1:0] RF_WDATA,
    output logic RF_WE,
    output logic [DATA_W-1:0] WORKING_ACCUMULATOR,
    output logic [4:0] STATUS_FLAGS,
    output logic [PC_W-1:0] PC_LOAD_VALUE,
    output logic PC_LOAD,
    output logic [1:0] PHASE,
    output logic STALL_NOP,
    output logic ILLEGAL
);
    localparam logic [DATA_W-1:0] ACCESS_SPLIT = 8'h80;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ADDC = 4'h1,
        OP_ANDL = 4'h2,
        OP_ANDR = 4'h3,
        OP_BCLR = 4'h4,
        OP_BRANCH = 4'h5
    } op_t;

    typedef struct packed {
        phase_t phase;
        op_t op;
        logic [15:0] ir;
        logic [PC_W-1:0] iaddr;
        logic [DATA_W-1:0] opnd;
        logic [DATA_W-1:0] res;
        logic [DATA_W-1:0] wacc;
        flags_t flags;
        logic take;
        logic nop_cycle;
        logic [BANK_W+DATA_W-1:0] addr;
        logic rf_re;
        logic rf_we;
        logic [PC_W-1:0] pc_val;
        logic pc_ld;
        logic illegal;
    } state_t;

    state_t st_reg;
    state_t st_next;
    alu_exec_if ax();
    logic [7:0] hi;
    logic cond;
    logic [PC_W-1:0] offs;
    flags_t fl_merge;

    alu_exec_unit u_alu (
        .x(ax)
    );

    assign hi = st_reg.ir[15:8];

    // feed the arithmetic unit from the latched operands
    always_comb begin
        ax.acc = st_reg.wacc;
        ax.opnd = (st_reg.op == OP_ANDL) ? st_reg.ir[7:0] : st_reg.opnd;
        ax.carry_in = st_reg.flags.c;
        ax.sel_add = (st_reg.op == OP_ADDC);
        ax.sel_and = (st_reg.op == OP_ANDL) || (st_reg.op == OP_ANDR);
        ax.sel_bclr = (st_reg.op == OP_BCLR);
        // bit number sits in the upper byte of the word
        ax.bit_sel = st_reg.ir[8+B_LSB+2:8+B_LSB];
    end

    // branch condition from the current flags
    always_comb begin
        case (hi)
            OPC_BRC: cond = st_reg.flags.c;
            OPC_BRNC: cond = !st_reg.flags.c;
            OPC_BRN: cond = st_reg.flags.n;
            OPC_BRNN: cond = !st_reg.flags.n;
            OPC_BRNOV: cond = !st_reg.flags.ov;
            default: cond = 1'b0;
        endcase
        // sign-extend then double the offset
        offs = PC_W'({{(PC_W-DATA_W){st_reg.ir[7]}}, st_reg.ir[7:0]} << 1);
        fl_merge.n = ax.flag_we[4] ? ax.flags_out.n : st_reg.flags.n;
        fl_merge.ov = ax.flag_we[3] ? ax.flags_out.ov : st_reg.flags.ov;
        fl_merge.z = ax.flag_we[2] ? ax.flags_out.z : st_reg.flags.z;
        fl_merge.dc = ax.flag_we[1] ? ax.flags_out.dc : st_reg.flags.dc;
        fl_merge.c = ax.flag_we[0] ? ax.flags_out.c : st_reg.flags.c;
    end

    // one phase per clock; a taken branch adds a nop cycle
    always_comb begin
        st_next = st_reg;
        st_next.pc_ld = 1'b0;
        st_next.rf_we = 1'b0;
        st_next.rf_re = 1'b0;
        st_next.phase = phase_t'(st_reg.phase + 2'b01);
        case (st_reg.phase)
            PH_DECODE: begin
                st_next.ir = INSTR;
                st_next.iaddr = INSTR_ADDR;
                st_next.illegal = 1'b0;
                if (st_reg.nop_cycle) begin
                    st_next.op = OP_NONE; // flushed slot
                end else if ((INSTR[15:8] & MSK_ADDC) == OPC_ADDC) begin
                    st_next.op = OP_ADDC;
                end else if (INSTR[15:8] == OPC_ANDL) begin
                    st_next.op = OP_ANDL;
                end else if ((INSTR[15:8] & MSK_ADDC) == OPC_ANDR) begin
                    st_next.op = OP_ANDR;
                end else if ((INSTR[15:8] & MSK_BCLR) == OPC_BCLR) begin
                    st_next.op = OP_BCLR;
                end else if (INSTR[15:8] == OPC_BRC || INSTR[15:8] == OPC_BRNC
                        || INSTR[15:8] == OPC_BRN || INSTR[15:8] == OPC_BRNN
                        || INSTR[15:8] == OPC_BRNOV) begin
                    st_next.op = OP_BRANCH;
                end else begin
                    st_next.op = OP_NONE;
                    st_next.illegal = 1'b1; // outside this block's subset
                end
                // bank choice: access bank or pointer
                if (!INSTR[8 + A_BIT]) begin
                    st_next.addr = {(INSTR[7:0] < ACCESS_SPLIT) ? ACCESS_LO_BANK
                        : ACCESS_HI_BANK, INSTR[7:0]};
                end else begin
                    st_next.addr = {BANK_SELECT_POINTER, INSTR[7:0]};
                end
            end
            PH_READ: begin
                // register read for register-operand ops
                if (st_reg.op == OP_ADDC || st_reg.op == OP_ANDR
                        || st_reg.op == OP_BCLR) begin
                    st_next.rf_re = 1'b1;
                    st_next.opnd = RF_RDATA;
                end
            end
            PH_PROCESS: begin
                st_next.res = ax.result;
                st_next.take = (st_reg.op == OP_BRANCH) && cond;
            end
            PH_WRITE: begin
                st_next.nop_cycle = 1'b0;
                case (st_reg.op)
                    OP_ADDC, OP_ANDR: begin
                        st_next.flags = fl_merge;
                        if (st_reg.ir[8 + D_BIT]) begin
                            st_next.rf_we = 1'b1; // d=1 register
                        end else begin
                            st_next.wacc = st_reg.res; // d=0 accumulator
                        end
                    end
                    OP_ANDL: begin
                        st_next.flags = fl_merge;
                        st_next.wacc = st_reg.res;
                    end
                    OP_BCLR: begin
                        st_next.rf_we = 1'b1; // write back, flags kept
                    end
                    OP_BRANCH: begin
                        if (st_reg.take) begin
                            st_next.pc_val = PC_W'(st_reg.iaddr + PC_STEP + offs);
                            st_next.pc_ld = 1'b1;
                            st_next.nop_cycle = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            default: begin
                st_next.phase = PH_DECODE;
            end
        endcase
    end

    // single state register, synchronous reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign RF_ADDR = st_reg.addr;
    assign RF_RE = st_reg.rf_re;
    assign RF_WDATA = st_reg.res;
    assign RF_WE = st_reg.rf_we;
    assign WORKING_ACCUMULATOR = st_reg.wacc;
    assign STATUS_FLAGS = st_reg.flags;
    assign PC_LOAD_VALUE = st_reg.pc_val;
    assign PC_LOAD = st_reg.pc_ld;
    assign PHASE = st_reg.phase;
    assign STALL_NOP = st_reg.nop_cycle;
    assign ILLEGAL = st_reg.illegal;
endmodule
`default_nettype wire

// File: alu_branch_instr_decode_asserts.sv
// assertions on the decoder's top ports
// assumes it is bound in from the bench; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module alu_branch_instr_decode_asserts
    import alu_branch_pkg::*;
(
    input wire logic CLK, RST, RF_WE, RF_RE, PC_LOAD, STALL_NOP,
    input wire logic [15:0] INSTR,
    input wire logic [PC_W-1:0] INSTR_ADDR, PC_LOAD_VALUE,
    input wire logic [BANK_W-1:0] BANK_SELECT_POINTER,
    input wire logic [DATA_W-1:0] RF_WDATA,
    input wire logic [BANK_W+DATA_W-1:0] RF_ADDR,
    input wire logic [4:0] STATUS_FLAGS,
    input wire logic [1:0] PHASE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // a word is taken only in phase zero outside the branch nop
    wire iss = PHASE == 2'd0 && !STALL_NOP;
    wire rop = INSTR[15:10] == 6'h08 || INSTR[15:10] == 6'h05 || INSTR[15:12] == 4'h9;
    wire [BANK_W-1:0] bk = INSTR[8] ? BANK_SELECT_POINTER : INSTR[7] ? 4'hF : 4'h0;
    wire [PC_W-1:0] tgt = INSTR_ADDR + PC_STEP + {{12{INSTR[7]}}, INSTR[7:0], 1'b0};
    AST_PHASE: assert property (1 |=> PHASE == $past(PHASE) + 2'd1)
        else $error("phase skipped");
    AST_STROBE: assert property (RF_WE || PC_LOAD |-> PHASE == 2'd0)
        else $error("strobe outside phase zero");
    AST_LOAD_NOP: assert property (PC_LOAD |-> STALL_NOP && !RF_WE)
        else $error("pc load without nop");
    AST_NOP_LEN: assert property ($rose(STALL_NOP) |-> STALL_NOP [*4] ##1 !STALL_NOP)
        else $error("nop cycle not four clocks");
    AST_BRF: assert property (STALL_NOP |-> $stable(STATUS_FLAGS))
        else $error("flags moved on branch");
    AST_BANK: assert property (iss && rop |=> RF_ADDR == $past({bk, INSTR[7:0]}))
        else $error("wrong bank");
    AST_READ: assert property (iss && rop |=> !RF_RE ##1 RF_RE)
        else $error("register read not in phase two");
    AST_TARGET: assert property (PC_LOAD |-> PC_LOAD_VALUE == $past(tgt, 4))
        else $error("wrong branch target");
    AST_BCLR: assert property (iss && INSTR[15:12] == 4'h9 |-> ##4 RF_WE
        && RF_WDATA[$past(INSTR[11:9], 4)] == 1'b0)
        else $error("bit not cleared");
endmodule
`default_nettype wire

// File: rf_model.sv
// data memory behind the decoder's register-file port
// assumes a write lands on the edge that ends the write strobe
`timescale 1ns/1ps
`default_nettype none
module rf_model (
    input wire logic clk,
    input wire logic [11:0] addr,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [4096];
    // cells start from an address pattern so misaddressing shows
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i) ^ {2{4'(i >> 8)}};
        end
    end
    // combinational answer, sampled by the decoder in phase one
    assign rdata = mem[addr];
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end
endmodule
`default_nettype wire

// File: alu_branch_instr_decode_tb.sv
// random instruction stream checked against a model in the bench
// assumes rf_model answers reads at once; checker bound at the foot
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module alu_branch_instr_decode_tb;
    import alu_branch_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [15:0] INSTR = 16'h0000;
    logic [PC_W-1:0] INSTR_ADDR = 21'h000000;
    logic [BANK_W-1:0] BANK_SELECT_POINTER = 4'h0;
    logic [7:0] RF_RDATA, RF_WDATA, WORKING_ACCUMULATOR, acc = 8'h00;
    logic [PC_W-1:0] PC_LOAD_VALUE;
    logic [11:0] RF_ADDR;
    logic RF_RE, RF_WE, PC_LOAD, STALL_NOP, ILLEGAL;
    logic [4:0] STATUS_FLAGS, fl = 5'h00;
    logic [1:0] PHASE, last = 2'h0;
    logic [44:0] notes [$];
    logic [44:0] exp_v, got;
    logic [7:0] wr [int];
    logic [7:0] op [9] = '{OPC_ADDC, OPC_ANDL, OPC_ANDR, OPC_BCLR, OPC_BRC, OPC_BRNC,
        OPC_BRN, OPC_BRNN, OPC_BRNOV};
    logic [31:0] lfsr = 32'h78F78ECE;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    alu_branch_instr_decode i_dut (.CLK, .RST, .INSTR, .INSTR_ADDR, .BANK_SELECT_POINTER,
        .RF_RDATA, .RF_ADDR, .RF_RE, .RF_WDATA, .RF_WE, .WORKING_ACCUMULATOR, .STATUS_FLAGS,
        .PC_LOAD_VALUE, .PC_LOAD, .PHASE, .STALL_NOP, .ILLEGAL);
    rf_model i_rf (.clk(CLK), .addr(RF_ADDR), .we(RF_WE), .wdata(RF_WDATA), .rdata(RF_RDATA));
    always #25 CLK = ~CLK;
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // present one word in phase zero and note what the next phase zero shows
    task automatic issue(input logic [15:0] w);
        logic [11:0] ad;
        logic [8:0] s;
        logic [7:0] f, r;
        logic [4:0] h;
        logic we, tk, il;
        ad = {w[8] ? BANK_SELECT_POINTER : w[7] ? 4'hF : 4'h0, w[7:0]};
        f = wr.exists(ad) ? wr[ad] : ad[7:0] ^ {2{ad[11:8]}};
        we = 1'b0;
        tk = 1'b0;
        il = 1'b0;
        r = acc & (w[15:8] == OPC_ANDL ? w[7:0] : f);
        s = 9'(acc) + 9'(f) + 9'(fl[0]);
        h = 5'(acc[3:0]) + 5'(f[3:0]) + 5'(fl[0]);
        INSTR = w;
        if ((w[15:8] & MSK_ADDC) == OPC_ADDC) begin
            r = s[7:0];
            // overflow judged on the full sum, carry in included
            fl = {r[7], acc[7] == f[7] && r[7] != acc[7], r == 8'h00, h[4], s[8]};
            we = w[9];
        end else if ((w[15:8] & MSK_BCLR) == OPC_BCLR) begin
            r = f & ~(8'h01 << w[11:9]);
            we = 1'b1;
        end else if (w[15:8] == OPC_ANDL || (w[15:8] & MSK_ADDC) == OPC_ANDR) begin
            fl[4] = r[7];
            fl[2] = r == 8'h00;
            we = w[15:8] != OPC_ANDL && w[9];
        end else if (w[15:12] == 4'hE) begin
            case (w[11:8])
                4'h2: tk = fl[0];
                4'h3: tk = !fl[0];
                4'h6: tk = fl[4];
                4'h7: tk = !fl[4];
                default: tk = !fl[3];
            endcase
        end else begin
            il = 1'b1; // outside the subset, flagged and ignored
        end
        // words outside the subset leave memory alone, and the accumulator too unless their top nibble is below 3
        if (we) wr[ad] = r;
        else if (w[15:12] < 4'h3) acc = r;
        notes.push_back({il, acc, fl, we, tk, we ? r : 8'h00,
            tk ? INSTR_ADDR + PC_STEP + {{12{w[7]}}, w[7:0], 1'b0} : 21'h0});
        repeat (4) @(posedge CLK);
        #1;
        if (tk) begin
            INSTR = 16'(rnd()); // must be ignored in the nop cycle
            notes.push_back({1'b0, acc, fl, 31'h0});
            repeat (4) @(posedge CLK);
            #1;
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        logic [31:0] v;
        int j;
        repeat (16) @(posedge CLK);
        #1;
        `CHK({WORKING_ACCUMULATOR, STATUS_FLAGS, PHASE, RF_WE, PC_LOAD, ILLEGAL, STALL_NOP, RF_RE}, 20'h00000)
        RST = 1'b0;
        issue(16'hFFFF);
        issue({OPC_BRNC, 8'h80});
        issue({OPC_BRNN, 8'h7F});
        for (int i = 0; i < 400; i++) begin
            v = rnd();
            BANK_SELECT_POINTER = v[3:0];
            INSTR_ADDR = {v[20:1], 1'b0};
            v = rnd();
            j = v[31:16] % 9;
            if (j == 0 || j == 2) v[15:8] = op[j] | {6'h00, v[9:8]};
            else if (j == 3) v[15:8] = op[j] | {4'h0, v[11:8]};
            else v[15:8] = op[j];
            issue(v[15:0]);
        end
        repeat (2) @(posedge CLK);
        // a stuck sequencer leaves notes behind and must not pass
        `CHK(notes.size(), 0)
        stop_test();
    end
    // watcher: a result is due each time phase wraps round to zero
    always @(posedge CLK) begin
        #2;
        cyc++;
        if (cyc > 5000) begin
            errors++;
            stop_test();
        end
        if (PHASE === 2'd0 && last === 2'd3 && notes.size() > 0) begin
            exp_v = notes.pop_front();
            got = {ILLEGAL, WORKING_ACCUMULATOR, STATUS_FLAGS, RF_WE, PC_LOAD,
                RF_WE ? RF_WDATA : 8'h00, PC_LOAD ? PC_LOAD_VALUE : 21'h0};
            `CHK(got, exp_v)
        end
        last = PHASE;
    end
endmodule
bind alu_branch_instr_decode alu_branch_instr_decode_asserts i_chk (.CLK, .RST, .RF_WE, .RF_RE,
    .PC_LOAD, .STALL_NOP, .INSTR, .INSTR_ADDR, .PC_LOAD_VALUE, .BANK_SELECT_POINTER,
    .RF_WDATA, .RF_ADDR, .STATUS_FLAGS, .PHASE);
`default_nettype wire
